// file: logic/fblk_map.svh
// register offsets, command codes and field positions of the flash lock block
`ifndef FBLK_MAP_SVH
`define FBLK_MAP_SVH
// command codes
`define FBLK_CMD_LOCK_SETUP   16'h0060
`define FBLK_CMD_LOCK         16'h0001
`define FBLK_CMD_UNLOCK       16'h00D0
`define FBLK_CMD_LOCKDOWN     16'h002F
`define FBLK_CMD_CFG_READ     16'h0003
`define FBLK_CMD_CFG_ENH      16'h0004
`define FBLK_CMD_OTP_SETUP    16'h00C0
`define FBLK_CMD_READ_ARRAY   16'h00FF
`define FBLK_CMD_READ_STATUS  16'h0070
`define FBLK_CMD_CLEAR_STATUS 16'h0050
`define FBLK_CMD_READ_INFO    16'h0090
`define FBLK_CMD_WORD_PROG    16'h0041
`define FBLK_CMD_BUF_PROG     16'h00E9
`define FBLK_CMD_ERASE        16'h0020
// flash address layout: 4-bit block, 8-bit word offset
`define FBLK_BLOCK_MSB        11
`define FBLK_BLOCK_LSB        8
`define FBLK_LOCK_STATE_OFS   8'h02
// one-time space inside info mode: word offsets 0x40..0xC9
// base sits low so all 138 words fit under an 8-bit offset
`define FBLK_OTP_BASE         8'h40
`define FBLK_OTP_LOCK0        8'h40
`define FBLK_OTP_LOCK1        8'h41
`define FBLK_OTP_DATA0        8'h42
`define FBLK_OTP_WORDS        8'h8A
// status bit positions
`define FBLK_SR_LOCK_ERR      1
`define FBLK_SR_PROG_ERR      4
`define FBLK_SR_READY         7
// host control port offsets
`define FBLK_HOST_ADDR        4'h0
`define FBLK_HOST_DATA        4'h1
`define FBLK_HOST_GO          4'h2
`define FBLK_HOST_STATUS      4'h3
`define FBLK_HOST_RDATA       4'h4
`endif

// file: logic/fblk_pkg.sv
// types shared by both ends of the flash lock link
package fblk_pkg;
    typedef enum logic [2:0]
    {
        FBLK_RD_ARRAY  = 3'b001,
        FBLK_RD_STATUS = 3'b010,
        FBLK_RD_INFO   = 3'b100
    } fblk_rmode_t;
    typedef enum logic [3:0]
    {
        FBLK_IDLE      = 4'b0001,
        FBLK_LOCK_WAIT = 4'b0010,
        FBLK_OTP_WAIT  = 4'b0100,
        FBLK_PROG_WAIT = 4'b1000
    } fblk_cmd_t;
endpackage

// file: logic/fblk_bus_if.sv
// flash bus between the memory controller and the lock block
`timescale 1ns/1ps
interface fblk_bus_if;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
    logic [15:0] rdata;
    logic        wp_n;
    modport ctrl (output addr, output wdata, output we, output re, output wp_n, input rdata);
    modport dev  (input addr, input wdata, input we, input re, input wp_n, output rdata);
endinterface

// file: logic/fblk_host.sv
// memory controller end: turns register orders into flash bus cycles
`timescale 1ns/1ps
module fblk_host
    import fblk_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    // register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    // protect level
    input  wire logic        WP_N,
    // flash bus
    fblk_bus_if.ctrl         bus
);
`include "fblk_map.svh"
    logic [15:0] cyc_addr;
    logic [15:0] cyc_data;
    logic [15:0] last_read;
    logic        rd_pend;
    // ==========================================================
    // order registers
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
        begin
            cyc_addr <= 16'h0000;
            cyc_data <= 16'h0000;
        end
        else if (WR && ADDR == `FBLK_HOST_ADDR)
            cyc_addr <= WDATA;
        else if (WR && ADDR == `FBLK_HOST_DATA)
            cyc_data <= WDATA;
    // ==========================================================
    // bus cycles: go bit0 = write cycle, bit1 = read cycle
    // lock setup then confirm issued as two writes
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
        begin
            bus.we  <= 1'b0;
            bus.re  <= 1'b0;
            bus.addr  <= 16'h0000;
            bus.wdata <= 16'h0000;
        end
        else
        begin
            bus.we    <= WR && ADDR == `FBLK_HOST_GO && WDATA[0];
            bus.re    <= WR && ADDR == `FBLK_HOST_GO && WDATA[1] && !WDATA[0];
            bus.addr  <= cyc_addr;
            bus.wdata <= cyc_data;
        end
    assign bus.wp_n = WP_N;
    // device answers combinationally in the read cycle
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
        begin
            last_read <= 16'h0000;
            rd_pend   <= 1'b0;
        end
        else
        begin
            rd_pend <= bus.re;
            if (bus.re)
                last_read <= bus.rdata;
        end
    // ==========================================================
    // read port
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
            RDATA <= 16'h0000;
        else if (RD)
            case (ADDR)
                `FBLK_HOST_ADDR:   RDATA <= cyc_addr;
                `FBLK_HOST_DATA:   RDATA <= cyc_data;
                `FBLK_HOST_STATUS: RDATA <= {15'h0000, rd_pend | bus.re | bus.we};
                `FBLK_HOST_RDATA:  RDATA <= last_read;
                default:           RDATA <= 16'h0000;
            endcase
        else
            RDATA <= 16'h0000;
endmodule

// file: logic/fblk_dev.sv
// flash device end: command decode, block locking and one-time registers
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module fblk_dev
    import fblk_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    // flash bus
    fblk_bus_if.dev          bus,
    // array engine state
    input  wire logic        ARRAY_BUSY,
    input  wire logic        PROG_SUSPENDED,
    input  wire logic        ERASE_SUSPENDED,
    input  wire logic [3:0]  BUSY_BLOCK,
    // array requests
    output logic             PROG_REQ,
    output logic             BUF_PROG_REQ,
    output logic             ERASE_REQ,
    output logic      [15:0] REQ_ADDR,
    output logic      [15:0] REQ_DATA,
    // configuration and mode
    output logic      [15:0] READ_CONFIG_WORD,
    output logic      [15:0] ENHANCED_CONFIG_WORD,
    output logic      [2:0]  READ_MODE
);
`include "fblk_map.svh"
    parameter logic [63:0] FACTORY_ID = 64'h0123_4567_89AB_CDEF; // arbitrary value
    localparam int NWORDS = 138;

    fblk_cmd_t   state;
    fblk_rmode_t rmode;
    logic [15:0] lock_bit;
    logic [15:0] lockdown;
    logic [15:0] otp [NWORDS];
    logic [7:0]  status;
    logic        wp_s1;
    logic        wp_s2;
    logic [3:0]  blk;
    logic [7:0]  ofs;
    logic [7:0]  otp_idx;
    logic        otp_locked;
    logic        blk_eff_locked;

    function automatic logic [3:0] block_of(input logic [15:0] a);
        return a[`FBLK_BLOCK_MSB:`FBLK_BLOCK_LSB];
    endfunction

    // ==========================================================
    // protect pin synchroniser
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
        begin
            wp_s1 <= 1'b0;
            wp_s2 <= 1'b0;
        end
        else
        begin
            wp_s1 <= bus.wp_n;
            wp_s2 <= wp_s1;
        end

    assign blk     = block_of(bus.addr);
    assign ofs     = bus.addr[7:0];
    assign otp_idx = 8'(ofs - `FBLK_OTP_BASE);
    assign blk_eff_locked = lock_bit[blk] | (lockdown[blk] & ~wp_s2);
    // guard word zero bit 0 for register zero, word one bits 0..15 for 1..16
    always_comb
    begin
        if (otp_idx == 8'd0 || otp_idx == 8'd1)
            otp_locked = 1'b0;
        else if (otp_idx < 8'd10)
            otp_locked = ~otp[0][0] | (otp_idx < 8'd6);
        else
            otp_locked = ~otp[1][4'((otp_idx - 8'd10) >> 3)];
    end

    // ==========================================================
    // command sequencer
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
            state <= FBLK_IDLE;
        else if (bus.we)
            case (state)
                FBLK_IDLE:
                    case (bus.wdata)
                        `FBLK_CMD_LOCK_SETUP: state <= FBLK_LOCK_WAIT;
                        `FBLK_CMD_OTP_SETUP:  state <= FBLK_OTP_WAIT;
                        `FBLK_CMD_WORD_PROG:  state <= FBLK_PROG_WAIT;
                        default:              state <= FBLK_IDLE;
                    endcase
                default:
                    state <= FBLK_IDLE;
            endcase

    // ==========================================================
    // read mode per write
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
            rmode <= FBLK_RD_ARRAY;
        else if (bus.we && state == FBLK_IDLE)
            case (bus.wdata)
                `FBLK_CMD_READ_ARRAY:  rmode <= FBLK_RD_ARRAY;
                `FBLK_CMD_READ_STATUS: rmode <= FBLK_RD_STATUS;
                `FBLK_CMD_READ_INFO:   rmode <= FBLK_RD_INFO;
                `FBLK_CMD_LOCK_SETUP:  rmode <= FBLK_RD_STATUS;
                `FBLK_CMD_WORD_PROG,
                `FBLK_CMD_BUF_PROG,
                `FBLK_CMD_ERASE:       rmode <= FBLK_RD_STATUS;
                default:               rmode <= rmode;
            endcase
    assign READ_MODE = rmode;

    // ==========================================================
    // block lock state
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
        begin
            lock_bit <= 16'hFFFF;
            lockdown <= 16'h0000;
        end
        else if (bus.we && state == FBLK_LOCK_WAIT && !ARRAY_BUSY && !PROG_SUSPENDED)
        begin
            // takes effect now, erase resumes untouched
            case (bus.wdata)
                `FBLK_CMD_LOCK:     lock_bit[blk] <= 1'b1;
                // unlock confirm, a locked-down block only when protect high
                `FBLK_CMD_UNLOCK:   if (!(lockdown[blk] && !wp_s2)) lock_bit[blk] <= 1'b0;
                `FBLK_CMD_LOCKDOWN: lockdown[blk] <= 1'b1;
                default:            lock_bit <= lock_bit;
            endcase
        end
        // protect low relocks all marked blocks
        else if (!wp_s2)
            lock_bit <= lock_bit | lockdown;

    // ==========================================================
    // configuration words, captured from the address bus
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
        begin
            READ_CONFIG_WORD     <= 16'h0000;
            ENHANCED_CONFIG_WORD <= 16'h0000;
        end
        else if (bus.we && state == FBLK_LOCK_WAIT)
        begin
            if (bus.wdata == `FBLK_CMD_CFG_READ)
                READ_CONFIG_WORD <= bus.addr;
            if (bus.wdata == `FBLK_CMD_CFG_ENH)
                ENHANCED_CONFIG_WORD <= bus.addr;
        end

    // ==========================================================
    // one-time storage and status flags
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
        begin
            // guard words plus 17 x 8 data words
            // register zero low half factory, locked by layout
            for (int i = 0; i < NWORDS; i++)
                otp[i] <= 16'hFFFF;
            for (int i = 0; i < 4; i++)
                otp[2 + i] <= FACTORY_ID[16*i +: 16];
            status <= 8'h80;
        end
        else if (bus.we && state == FBLK_OTP_WAIT)
        begin
            // data word goes to the addressed register
            if (ofs < `FBLK_OTP_BASE || otp_idx >= `FBLK_OTP_WORDS)
                status[`FBLK_SR_PROG_ERR] <= 1'b1;
            else if (otp_locked)
            begin
                status[`FBLK_SR_PROG_ERR] <= 1'b1;
                status[`FBLK_SR_LOCK_ERR] <= 1'b1;
            end
            else
                otp[otp_idx] <= otp[otp_idx] & bus.wdata;
        end
        else if (bus.we && state == FBLK_PROG_WAIT && blk_eff_locked)
        begin
            status[`FBLK_SR_PROG_ERR] <= 1'b1;
            status[`FBLK_SR_LOCK_ERR] <= 1'b1;
        end
        else if (bus.we && state == FBLK_IDLE && bus.wdata == `FBLK_CMD_CLEAR_STATUS)
            status <= 8'h80;

    // ==========================================================
    // array requests
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
        begin
            PROG_REQ     <= 1'b0;
            BUF_PROG_REQ <= 1'b0;
            ERASE_REQ    <= 1'b0;
            REQ_ADDR     <= 16'h0000;
            REQ_DATA     <= 16'h0000;
        end
        else
        begin
            // word program latches on next write, unlocked only
            PROG_REQ     <= bus.we && state == FBLK_PROG_WAIT && !blk_eff_locked;
            BUF_PROG_REQ <= bus.we && state == FBLK_IDLE && bus.wdata == `FBLK_CMD_BUF_PROG && !blk_eff_locked;
            ERASE_REQ    <= bus.we && state == FBLK_IDLE && bus.wdata == `FBLK_CMD_ERASE && !blk_eff_locked
                            && !(ERASE_SUSPENDED && blk == BUSY_BLOCK);
            if (bus.we)
            begin
                REQ_ADDR <= bus.addr;
                REQ_DATA <= bus.wdata;
            end
        end

    // ==========================================================
    // read data, combinational within the read cycle
    always_comb
    begin
        bus.rdata = 16'h0000;
        if (bus.re)
            case (rmode)
                FBLK_RD_STATUS: bus.rdata = {8'h00, status};
                FBLK_RD_INFO:
                    // lock bit on DQ0, lock-down on DQ1
                    if (ofs == `FBLK_LOCK_STATE_OFS)
                        bus.rdata = {14'h0000, lockdown[blk], blk_eff_locked};
                    else if (ofs >= `FBLK_OTP_BASE && otp_idx < `FBLK_OTP_WORDS)
                        bus.rdata = otp[otp_idx];
                    else
                        bus.rdata = 16'h0000;
                default:        bus.rdata = 16'h0000;
            endcase
    end
endmodule

// file: verif/fblk_properties.sv
// bus checker for the flash lock link
`timescale 1ns/1ps
module fblk_properties
(
    // flash bus signals
    input wire logic        REF_CLK,
    input wire logic        RSTN,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic        we,
    input wire logic        re,
    input wire logic [15:0] rdata,
    input wire logic        wp_n
);
    // ==========================================
    // command tracking
    logic [15:0] ld;
    logic        pend, lpend, opend, info, sts, rclean, perr, lerr, clean;
    logic [2:0]  wlow;
    wire         cmd   = we && !pend;
    wire         start = cmd && wdata inside {16'h0060, 16'h00C0, 16'h0041, 16'h00E9, 16'h0020};
    wire         lsr   = re && info && addr[7:0] == 8'h02;
    wire         fact  = addr[7:0] inside {[8'h42:8'h45]};
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            {pend, lpend, opend, info, sts, perr, lerr, clean} <= '0;
            rclean <= 1'b1;
            ld     <= '0;
            wlow   <= '0;
        end
        else
        begin
            // protect low for four samples covers the relock latency
            wlow <= wp_n ? 3'd0 : (wlow == 3'd4 ? wlow : wlow + 3'd1);
            if (we)
            begin
                pend  <= start;
                lpend <= cmd && wdata == 16'h0060;
                opend <= cmd && wdata == 16'h00C0;
                info  <= cmd && wdata == 16'h0090;
                sts   <= cmd && wdata == 16'h0070;
                clean <= (clean || (cmd && wdata == 16'h0050)) && !start;
                if (cmd && wdata == 16'h0060)
                    rclean <= 1'b0;
                if (lpend && wdata == 16'h002F)
                    ld[addr[11:8]] <= 1'b1;
                if (opend && (addr[7:0] < 8'h40 || addr[7:0] > 8'hC9 || fact))
                    perr <= 1'b1;
                if (opend && fact)
                    lerr <= 1'b1;
                if (cmd && wdata == 16'h0050)
                    {perr, lerr} <= 2'b00;
            end
        end
    end
    // ==========================================
    // properties
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    AST_WE_PULSE: assert property (we |=> !we)
        else $error("write strobe held");
    AST_RE_PULSE: assert property (re |=> !re)
        else $error("read strobe held");
    AST_NO_OVERLAP: assert property (!(we && re))
        else $error("read and write together");
    AST_RESET_LOCK: assert property (lsr && rclean |-> rdata[1:0] == 2'b01)
        else $error("reset lock state wrong");
    AST_LD_FORCED: assert property (lsr && ld[addr[11:8]] && wlow == 3'd4 |-> rdata[1:0] == 2'b11)
        else $error("locked-down block not locked");
    AST_PROG_ERR: assert property (re && sts && perr |-> rdata[4])
        else $error("program error missing");
    AST_LOCK_ERR: assert property (re && sts && lerr |-> rdata[1])
        else $error("lock error missing");
    AST_CLEAR: assert property (re && sts && clean |-> !rdata[4] && !rdata[1])
        else $error("errors not cleared");
endmodule

// file: verif/tb_flash_block_lock_otp_commands.sv
// self-checking bench for the flash lock link
`timescale 1ns/1ps
module tb_flash_block_lock_otp_commands
    import fblk_pkg::*;
;
    logic        REF_CLK, RSTN, WR, RD, WP_N, busy, psus, esus, preq, bpreq, ereq;
    logic [3:0]  ADDR, bblk;
    logic [15:0] WDATA, RDATA, v, rqd, rqa, rcfg, ecfg;
    logic [2:0]  rmode;
    int          err_total = 0, check_count = 0, nprog = 0, nbuf = 0, nera = 0;
    fblk_bus_if  bus ();
    fblk_host i_fblk_host (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .WP_N(WP_N), .bus(bus));
    fblk_dev #(.FACTORY_ID(64'h1111_2222_3333_4444)) i_fblk_dev (.REF_CLK(REF_CLK), .RSTN(RSTN), .bus(bus),
        .ARRAY_BUSY(busy), .PROG_SUSPENDED(psus), .ERASE_SUSPENDED(esus), .BUSY_BLOCK(bblk), .PROG_REQ(preq),
        .BUF_PROG_REQ(bpreq), .ERASE_REQ(ereq), .REQ_ADDR(rqa), .REQ_DATA(rqd), .READ_CONFIG_WORD(rcfg),
        .ENHANCED_CONFIG_WORD(ecfg), .READ_MODE(rmode));
    fblk_properties i_fblk_properties (.REF_CLK(REF_CLK), .RSTN(RSTN), .addr(bus.addr), .wdata(bus.wdata),
        .we(bus.we), .re(bus.re), .rdata(bus.rdata), .wp_n(bus.wp_n));
    // ==========================================
    // clock, counting, tasks
    initial
    begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    // counted mid-cycle so a pulse never races the edge that reads it
    always @(negedge REF_CLK)
    begin
        if (preq === 1'b1)
            nprog++;
        if (bpreq === 1'b1)
            nbuf++;
        if (ereq === 1'b1)
            nera++;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rw(input logic [3:0] a, input logic [15:0] d);
        @(posedge REF_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge REF_CLK);
        WR    <= 1'b0;
    endtask
    task automatic rr(input logic [3:0] a, output logic [15:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge REF_CLK);
        RD   <= 1'b0;
        #1 d = RDATA;
    endtask
    // one flash write cycle issued through the host
    task automatic fw(input logic [15:0] a, input logic [15:0] d);
        rw(4'h0, a);
        rw(4'h1, d);
        rw(4'h2, 16'h0001);
        repeat (2) @(posedge REF_CLK);
    endtask
    task automatic fr(input logic [15:0] a, output logic [15:0] d);
        rw(4'h0, a);
        rw(4'h2, 16'h0002);
        repeat (2) @(posedge REF_CLK);
        rr(4'h4, d);
    endtask
    task automatic md(input fblk_rmode_t e);
        chk({13'h0, rmode}, {13'h0, e});
    endtask
    task automatic lk(input logic [3:0] b, input logic [15:0] c);
        fw({4'h0, b, 8'h00}, 16'h0060);
        fw({4'h0, b, 8'h00}, c);
    endtask
    task automatic ls(input logic [3:0] b, input logic [1:0] e);
        fw({4'h0, b, 8'h00}, 16'h0090);
        fr({4'h0, b, 8'h02}, v);
        chk({14'h0, v[1:0]}, {14'h0, e});
    endtask
    task automatic st(input logic [1:0] e);
        fw(16'h0000, 16'h0070);
        fr(16'h0000, v);
        chk({14'h0, v[4], v[1]}, {14'h0, e});
    endtask
    // ==========================================
    // watchdog and main sequence
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        err_total++;
        print_verdict();
    end
    initial
    begin
        {RSTN, WR, RD, busy, psus, esus, WP_N} = '0;
        ADDR  = 4'h0;
        WDATA = 16'h0000;
        bblk  = 4'h3;
        repeat (4) @(posedge REF_CLK);
        RSTN <= 1'b1;
        ls(4'h3, 2'b01);
        fw(16'h0340, 16'h0060);
        md(FBLK_RD_STATUS);
        fw(16'h0300, 16'h00D0);
        ls(4'h3, 2'b00);
        fw(16'h0400, 16'h0041);
        md(FBLK_RD_STATUS);
        fw(16'h0410, 16'h5A5A);
        chk(16'(nprog), 16'h0000);
        st(2'b11);
        fw(16'h0000, 16'h0050);
        fw(16'h0300, 16'h0041);
        fw(16'h0310, 16'hA5A5);
        chk(16'(nprog), 16'h0001);
        chk(rqd, 16'hA5A5);
        chk(rqa, 16'h0310);
        fw(16'h0400, 16'h0020);
        chk(16'(nera), 16'h0000);
        fw(16'h0300, 16'h0020);
        chk(16'(nera), 16'h0001);
        md(FBLK_RD_STATUS);
        fw(16'h0300, 16'h00FF);
        fw(16'h0300, 16'h00E9);
        chk(16'(nbuf), 16'h0001);
        md(FBLK_RD_STATUS);
        fw(16'h0300, 16'h00FF);
        fw(16'h0300, 16'h00FF);
        md(FBLK_RD_ARRAY);
        fw(16'h0300, 16'h0090);
        md(FBLK_RD_INFO);
        busy <= 1'b1;
        lk(4'h3, 16'h0001);
        busy <= 1'b0;
        ls(4'h3, 2'b00);
        psus <= 1'b1;
        lk(4'h3, 16'h0001);
        psus <= 1'b0;
        ls(4'h3, 2'b00);
        esus <= 1'b1;
        lk(4'h3, 16'h0001);
        ls(4'h3, 2'b01);
        esus <= 1'b0;
        WP_N <= 1'b1;
        lk(4'h5, 16'h00D0);
        lk(4'h5, 16'h002F);
        ls(4'h5, 2'b10);
        WP_N <= 1'b0;
        ls(4'h5, 2'b11);
        lk(4'h5, 16'h00D0);
        ls(4'h5, 2'b11);
        WP_N <= 1'b1;
        lk(4'h5, 16'h00D0);
        ls(4'h5, 2'b10);
        WP_N <= 1'b0;
        ls(4'h5, 2'b11);
        fw(16'h0000, 16'h0050);
        fw(16'h0700, 16'h00C0);
        fw(16'h0010, 16'h0000);
        st(2'b10);
        fw(16'h0000, 16'h0050);
        st(2'b00);
        fw(16'h0000, 16'h00C0);
        fw(16'h0042, 16'h0000);
        st(2'b11);
        fw(16'h0000, 16'h0050);
        fw(16'h0000, 16'h00C0);
        fw(16'h00CA, 16'h0000);
        st(2'b10);
        fw(16'h0000, 16'h0090);
        fr(16'h0042, v);
        chk(v, 16'h4444);
        fr(16'h0046, v);
        chk(v, 16'hFFFF);
        fr(16'h00C9, v);
        chk(v, 16'hFFFF);
        fw(16'h0000, 16'h00C0);
        fw(16'h004A, 16'hF0F0);
        fw(16'h0000, 16'h00C0);
        fw(16'h004A, 16'h0FFF);
        fw(16'h0000, 16'h0090);
        fr(16'h004A, v);
        chk(v, 16'h00F0);
        fw(16'h0000, 16'h0050);
        fw(16'h0000, 16'h00C0);
        fw(16'h0041, 16'hFFFE);
        fw(16'h0000, 16'h00C0);
        fw(16'h004A, 16'h0000);
        st(2'b11);
        fw(16'h0000, 16'h0090);
        fr(16'h004A, v);
        chk(v, 16'h00F0);
        fw(16'h0000, 16'h0060);
        fw(16'h1234, 16'h0003);
        fw(16'h0000, 16'h0060);
        fw(16'h0ABC, 16'h0004);
        chk(rcfg, 16'h1234);
        chk(ecfg, 16'h0ABC);
        RSTN <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        RSTN <= 1'b1;
        ls(4'h5, 2'b01);
        print_verdict();
    end
endmodule
